/* shared/ecall_defines.svh */
/*
 * Offsets, field positions, reset values and leaf codes of the enclave
 * call fault gate. Assumes inclusion by bare name from rtl files.
 */
`ifndef ECALL_DEFINES_SVH
`define ECALL_DEFINES_SVH

// ==========================================================
// Register offsets (byte addresses, one word each)
`define ECG_OFF_CTRL 8'h00
`define ECG_OFF_MAP_LO 8'h04
`define ECG_OFF_MAP_HI 8'h08
`define ECG_OFF_STATUS 8'h0C
`define ECG_OFF_COUNT 8'h10

// ==========================================================
// Control register bit positions
`define ECG_CTRL_FEAT_LOCK 0
`define ECG_CTRL_FEAT_EN 1
`define ECG_CTRL_BASE_SUP 2
`define ECG_CTRL_VMM_SUP 3
`define ECG_CTRL_VMM_EXEC 4
`define ECG_CTRL_VMM_EXIT 5
`define ECG_CTRL_TRK_USER 6
`define ECG_CTRL_TRK_SUP 7
`define ECG_CTRL_WIDTH 8
`define ECG_CTRL_RESET 8'h00

// ==========================================================
// Status register fields
`define ECG_STAT_KIND_LSB 0
`define ECG_STAT_ADDR64 3
`define ECG_STAT_LEAF_LSB 8

// ==========================================================
// Leaf codes and limits
`define ECG_LEAF_REPORT 32'h00000000
`define ECG_LEAF_KEY 32'h00000001
`define ECG_LEAF_ENTER 32'h00000002
`define ECG_LEAF_RESUME 32'h00000003
`define ECG_LEAF_EXIT 32'h00000004
`define ECG_LEAF_ACCEPT 32'h00000005
`define ECG_LEAF_EXT_PERM 32'h00000006
`define ECG_LEAF_ACC_COPY 32'h00000007
`define ECG_LEAF_DEC_SSA 32'h00000009
`define ECG_USER_LEAF_MAX 32'h00000009
`define ECG_VMM_LEAF_MAX 32'h00000002
`define ECG_MAP_LAST 32'h0000003F
`define ECG_PRIV_USER 2'h3
`define ECG_PRIV_KERNEL 2'h0

`endif

/* shared/ecall_pkg.sv */
/*
 * Types of the enclave call fault gate.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ecall_pkg;

	// ==========================================================
	// Outcome of one gate evaluation
	typedef enum logic [2:0] {
		RES_DISPATCH = 3'b000,
		RES_TXN_ABORT = 3'b001,
		RES_INVALID_OP = 3'b010,
		RES_GEN_PROT = 3'b011,
		RES_NO_DEVICE = 3'b100,
		RES_TRACK_VIOL = 3'b101,
		RES_VM_EXIT = 3'b110
	} result_type;

endpackage : ecall_pkg

/* rtl/leaf_decode.sv */
/*
 * Leaf index decode for both enclave call gates.
 * Assumes a leaf index already cut to the low 32 bits of the accumulator.
 */
`timescale 1ns/1ns
`include "ecall_defines.svh"

module leaf_decode (
	// Request
	input wire logic [31:0] leaf,
	input wire logic is_vmm,
	input wire logic inside_enclave,
	// Verdict
	output logic leaf_valid,
	output logic leaf_mode_bad
);

	// ==========================================================
	// Leaf legality
	// Every leaf from zero to the mode's limit passes, including undefined leaf 8 of the user call
	always_comb begin
		if (is_vmm) begin
			leaf_valid = (leaf <= `ECG_VMM_LEAF_MAX);
		end else begin
			leaf_valid = (leaf <= `ECG_USER_LEAF_MAX);
		end
	end

	// Enclave-mode conflicts only apply to the user call
	always_comb begin
		leaf_mode_bad = 1'b0;
		if (!is_vmm && inside_enclave) begin
			leaf_mode_bad = (leaf == `ECG_LEAF_ENTER) ||
				(leaf == `ECG_LEAF_RESUME);
		end else if (!is_vmm) begin
			leaf_mode_bad = (leaf == `ECG_LEAF_REPORT) ||
				(leaf == `ECG_LEAF_KEY) ||
				(leaf == `ECG_LEAF_EXIT) ||
				(leaf == `ECG_LEAF_ACCEPT) ||
				(leaf == `ECG_LEAF_EXT_PERM) ||
				(leaf == `ECG_LEAF_ACC_COPY) ||
				(leaf == `ECG_LEAF_DEC_SSA);
		end
	end

endmodule : leaf_decode

/* rtl/enclave_call_fault_gate.sv */
/*
 * Fault check and dispatch gate for the user and hypervisor enclave
 * calls, with a classic Wishbone slave for its configuration.
 * Assumes request inputs come from core logic on sys_clk.
 */
`timescale 1ns/1ns
`include "ecall_defines.svh"

// Operation
// - Leaf is low 32 accumulator bits
// - User call: protection off, v86, management mode fault
// - User call faults below privilege three
// - User call: paging, fpu error, bad leaf
// - User call device fault when task switched
// - Transaction abort first, then fixed check order
// - Feature lock or enable clear: protection fault
// - 64-bit width needs long mode and long code
// - User call rejects 16-bit outside 64-bit mode
// - Inside enclave: enter or resume fault
// - Outside enclave: in-enclave leaves fault
// - User call: branch tracking wait violates unless clean resume
// - Lock, opsize, rep, vex prefixes fault
// - Segment, address-size, rex prefixes ignored
// - User call needs base enclave support
// - VMM call needs virtualization and consistent mode
// - VMM call faults above privilege zero
// - Guest VMM call needs execution enable
// - Guest exit map selects VM exit
// - VMM call needs vmm leaf support
// - VMM call: expand-down outside 64-bit mode, paging, bad leaf
module enclave_call_fault_gate (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Wishbone slave
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [31:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	output logic [31:0] wb_dat_r,
	output logic wb_ack,
	// Instruction request
	input wire logic req_valid,
	input wire logic req_vmm,
	input wire logic [63:0] rax,
	input wire logic [1:0] priv_level,
	input wire logic pfx_lock,
	input wire logic pfx_opsize,
	input wire logic pfx_rep,
	input wire logic pfx_vex,
	// Core state
	input wire logic protect_en,
	input wire logic v86_flag,
	input wire logic sys_mgmt_mode,
	input wire logic paging_en,
	input wire logic native_fpu_err,
	input wire logic task_switched,
	input wire logic txn_active,
	input wire logic inside_enclave,
	input wire logic long_mode_active,
	input wire logic code_seg_long,
	input wire logic code_seg_default32,
	input wire logic data_seg_expand_down,
	input wire logic virt_op,
	input wire logic guest_op,
	input wire logic user_branch_track_state,
	input wire logic sup_branch_track_state,
	// Result
	output logic res_valid,
	output ecall_pkg::result_type res_kind,
	output logic res_gp_zero,
	output logic [31:0] res_leaf,
	output logic res_addr64
);

	// ==========================================================
	// Reset synchroniser
	logic rst_meta_q;
	logic rst_q;

	// Release is delayed two edges so all flops leave reset together
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_q <= 1'b0;
			rst_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_q <= rst_meta_q;
		end
	end

	// ==========================================================
	// Register file
	logic [`ECG_CTRL_WIDTH-1:0] ctrl_q;
	logic [63:0] exit_map_q;
	logic [31:0] count_q;
	logic bus_req;
	logic bus_wr;
	logic [7:0] bus_off;
	logic adr_hi_ok;

	assign bus_req = wb_cyc && wb_stb && !wb_ack;
	assign bus_wr = bus_req && wb_we;
	assign bus_off = wb_adr[7:0];
	assign adr_hi_ok = (wb_adr[31:8] == 24'h000000);

	// One-cycle answer; ack drops the cycle after it was given
	always_ff @(posedge sys_clk or negedge rst_q) begin
		if (!rst_q) begin
			wb_ack <= 1'b0;
		end else begin
			wb_ack <= bus_req;
		end
	end

	// Byte-lane writes to control and exit map
	always_ff @(posedge sys_clk or negedge rst_q) begin
		if (!rst_q) begin
			ctrl_q <= `ECG_CTRL_RESET;
			exit_map_q <= 64'h0000000000000000;
		end else if (bus_wr && adr_hi_ok) begin
			for (int b = 0; b < 4; b++) begin
				if (wb_sel[b]) begin
					if (bus_off == `ECG_OFF_CTRL && b == 0) begin
						ctrl_q <= wb_dat_w[7:0];
					end
					if (bus_off == `ECG_OFF_MAP_LO) begin
						exit_map_q[8*b +: 8] <= wb_dat_w[8*b +: 8];
					end
					if (bus_off == `ECG_OFF_MAP_HI) begin
						exit_map_q[32+8*b +: 8] <= wb_dat_w[8*b +: 8];
					end
				end
			end
		end
	end

	// Read mux; unmapped addresses answer with zero
	always_ff @(posedge sys_clk or negedge rst_q) begin
		if (!rst_q) begin
			wb_dat_r <= 32'h00000000;
		end else if (bus_req) begin
			wb_dat_r <= 32'h00000000;
			if (adr_hi_ok) begin
				unique case (bus_off)
					`ECG_OFF_CTRL: wb_dat_r <= {24'h000000, ctrl_q};
					`ECG_OFF_MAP_LO: wb_dat_r <= exit_map_q[31:0];
					`ECG_OFF_MAP_HI: wb_dat_r <= exit_map_q[63:32];
					`ECG_OFF_STATUS: begin
						wb_dat_r <= {16'h0000, res_leaf[7:0], 4'h0,
							res_addr64, res_kind};
					end
					`ECG_OFF_COUNT: wb_dat_r <= count_q;
					default: wb_dat_r <= 32'h00000000;
				endcase
			end
		end
	end

	// ==========================================================
	// Configuration fields
	logic feat_lock;
	logic feat_en;
	logic base_sup;
	logic vmm_sup;
	logic vmm_exec_en;
	logic vmm_exit_en;
	logic trk_en;

	assign feat_lock = ctrl_q[`ECG_CTRL_FEAT_LOCK];
	assign feat_en = ctrl_q[`ECG_CTRL_FEAT_EN];
	assign base_sup = ctrl_q[`ECG_CTRL_BASE_SUP];
	assign vmm_sup = ctrl_q[`ECG_CTRL_VMM_SUP];
	assign vmm_exec_en = ctrl_q[`ECG_CTRL_VMM_EXEC];
	assign vmm_exit_en = ctrl_q[`ECG_CTRL_VMM_EXIT];
	// Tracking enable follows the privilege level in force
	assign trk_en = (priv_level == `ECG_PRIV_USER) ?
		ctrl_q[`ECG_CTRL_TRK_USER] : ctrl_q[`ECG_CTRL_TRK_SUP];

	// ==========================================================
	// Request decode
	logic [31:0] leaf;
	logic mode64;
	logic bad_prefix;
	logic leaf_valid;
	logic leaf_mode_bad;
	logic tracker_wait;
	logic map_hit;
	logic [5:0] map_idx;

	// Upper accumulator half never reaches the leaf decode
	assign leaf = rax[31:0];
	assign mode64 = long_mode_active && code_seg_long;
	// Segment, address-size and rex prefixes have no input at all
	assign bad_prefix = pfx_lock || pfx_opsize || pfx_rep || pfx_vex;
	assign tracker_wait = (priv_level == `ECG_PRIV_USER) ?
		user_branch_track_state : sup_branch_track_state;
	assign map_idx = (leaf > 32'h0000003E) ? 6'h3F : leaf[5:0];
	assign map_hit = exit_map_q[map_idx];

	leaf_decode leaf_decode_inst (
		.leaf(leaf),
		.is_vmm(req_vmm),
		.inside_enclave(inside_enclave),
		.leaf_valid(leaf_valid),
		.leaf_mode_bad(leaf_mode_bad)
	);

	// ==========================================================
	// Fault priority, evaluated in architectural order
	ecall_pkg::result_type kind_d;

	always_comb begin
		kind_d = ecall_pkg::RES_DISPATCH;
		if (txn_active) begin
			kind_d = ecall_pkg::RES_TXN_ABORT;
		end else if (bad_prefix) begin
			kind_d = ecall_pkg::RES_INVALID_OP;
		end else if (!req_vmm) begin
			if (trk_en && tracker_wait && (leaf != `ECG_LEAF_RESUME ||
				task_switched || sys_mgmt_mode || !base_sup ||
				priv_level != `ECG_PRIV_USER)) begin
				kind_d = ecall_pkg::RES_TRACK_VIOL;
			end else if (!protect_en || v86_flag || sys_mgmt_mode) begin
				kind_d = ecall_pkg::RES_INVALID_OP;
			end else if (!base_sup) begin
				kind_d = ecall_pkg::RES_INVALID_OP;
			end else if (task_switched) begin
				kind_d = ecall_pkg::RES_NO_DEVICE;
			end else if (priv_level != `ECG_PRIV_USER) begin
				kind_d = ecall_pkg::RES_INVALID_OP;
			end else if (!feat_lock || !feat_en) begin
				kind_d = ecall_pkg::RES_GEN_PROT;
			end else if (!leaf_valid) begin
				kind_d = ecall_pkg::RES_GEN_PROT;
			end else if (!paging_en || !native_fpu_err) begin
				kind_d = ecall_pkg::RES_GEN_PROT;
			end else if (!mode64 && !code_seg_default32) begin
				kind_d = ecall_pkg::RES_GEN_PROT;
			end else if (leaf_mode_bad) begin
				kind_d = ecall_pkg::RES_GEN_PROT;
			end
		end else begin
			if (!protect_en || v86_flag || sys_mgmt_mode || !vmm_sup) begin
				kind_d = ecall_pkg::RES_INVALID_OP;
			end else if (!virt_op ||
				(long_mode_active && !code_seg_long)) begin
				kind_d = ecall_pkg::RES_INVALID_OP;
			end else if (priv_level != `ECG_PRIV_KERNEL) begin
				kind_d = ecall_pkg::RES_INVALID_OP;
			end else if (guest_op && !vmm_exec_en) begin
				kind_d = ecall_pkg::RES_INVALID_OP;
			end else if (guest_op && vmm_exit_en && map_hit) begin
				kind_d = ecall_pkg::RES_VM_EXIT;
			end else if (!feat_lock || !feat_en) begin
				kind_d = ecall_pkg::RES_GEN_PROT;
			end else if (!leaf_valid || !paging_en) begin
				kind_d = ecall_pkg::RES_GEN_PROT;
			end else if (!mode64 && data_seg_expand_down) begin
				kind_d = ecall_pkg::RES_GEN_PROT;
			end
		end
	end

	// ==========================================================
	// Result registers
	// Only the verdict is reported; the core commits nothing on a fault
	always_ff @(posedge sys_clk or negedge rst_q) begin
		if (!rst_q) begin
			res_valid <= 1'b0;
		end else begin
			res_valid <= req_valid;
		end
	end

	// Verdict holds until the next request
	always_ff @(posedge sys_clk or negedge rst_q) begin
		if (!rst_q) begin
			res_kind <= ecall_pkg::RES_DISPATCH;
			res_gp_zero <= 1'b0;
			res_leaf <= 32'h00000000;
			res_addr64 <= 1'b0;
		end else if (req_valid) begin
			res_kind <= kind_d;
			res_gp_zero <= (kind_d == ecall_pkg::RES_GEN_PROT);
			res_leaf <= leaf;
			res_addr64 <= mode64;
		end
	end

	// Count of requests that were dispatched, wraps silently
	always_ff @(posedge sys_clk or negedge rst_q) begin
		if (!rst_q) begin
			count_q <= 32'h00000000;
		end else if (req_valid && kind_d == ecall_pkg::RES_DISPATCH) begin
			count_q <= count_q + 32'h00000001;
		end
	end

	// ==========================================================
	// Checks
	AST_TXN_FIRST: assert property (@(posedge sys_clk)
		disable iff (!rst_q)
		req_valid && txn_active |=> res_valid &&
		res_kind == ecall_pkg::RES_TXN_ABORT)
		else $error("transaction abort not taken first");

	AST_PREFIX_UD: assert property (@(posedge sys_clk)
		disable iff (!rst_q)
		req_valid && !txn_active && pfx_rep |=>
		res_kind == ecall_pkg::RES_INVALID_OP)
		else $error("bad prefix not refused");

	AST_USER_PRIV: assert property (@(posedge sys_clk)
		disable iff (!rst_q)
		req_valid && !req_vmm && priv_level != 2'h3 |=>
		res_kind != ecall_pkg::RES_DISPATCH)
		else $error("user call dispatched below privilege three");

	AST_USER_NM: assert property (@(posedge sys_clk)
		disable iff (!rst_q)
		req_valid && !req_vmm && !txn_active && !bad_prefix &&
		!(trk_en && tracker_wait) && protect_en && !v86_flag &&
		!sys_mgmt_mode && base_sup && task_switched |=>
		res_kind == ecall_pkg::RES_NO_DEVICE)
		else $error("task switched did not give device fault");

	AST_VMM_PRIV: assert property (@(posedge sys_clk)
		disable iff (!rst_q)
		req_valid && req_vmm && priv_level != 2'h0 |=>
		res_kind != ecall_pkg::RES_DISPATCH &&
		res_kind != ecall_pkg::RES_GEN_PROT)
		else $error("vmm call above privilege zero");

	// Clean hypervisor call with the feature off must give a zero-code fault
	AST_FEATURE_GP: assert property (@(posedge sys_clk)
		disable iff (!rst_q)
		req_valid && req_vmm && !txn_active && !bad_prefix && protect_en &&
		!v86_flag && !sys_mgmt_mode && vmm_sup && virt_op && mode64 &&
		priv_level == 2'h0 && !guest_op && (!feat_lock || !feat_en) |=>
		res_kind == ecall_pkg::RES_GEN_PROT && res_gp_zero)
		else $error("feature off did not give zero code protection fault");

	AST_LEAF_WORD: assert property (@(posedge sys_clk)
		disable iff (!rst_q)
		req_valid |=> res_leaf == $past(rax[31:0]))
		else $error("leaf not taken from low accumulator word");

	AST_ADDR64: assert property (@(posedge sys_clk)
		disable iff (!rst_q)
		req_valid |=> res_addr64 ==
		($past(long_mode_active) && $past(code_seg_long)))
		else $error("address width wrong");

	AST_VMEXIT_GUEST: assert property (@(posedge sys_clk)
		disable iff (!rst_q)
		req_valid && (!req_vmm || !guest_op || !vmm_exit_en) |=>
		res_kind != ecall_pkg::RES_VM_EXIT)
		else $error("vm exit without guest exit enable");

	AST_BUS_ACK: assert property (@(posedge sys_clk)
		disable iff (!rst_q)
		wb_cyc && wb_stb && !wb_ack |=> wb_ack ##1 !wb_ack)
		else $error("bus ack not one cycle after request");

endmodule : enclave_call_fault_gate

/* tb/test_enclave_call_fault_gate.sv */
/*
 * Self-checking bench of the enclave call fault gate.
 * Assumes the gate answers one cycle after req_valid and acks bus
 * cycles one cycle after the request is taken.
 */
`timescale 1ns/1ns
`include "ecall_defines.svh"

`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
	$display("[ERR] %0t got %h exp %h", $time, (a), (e)); \
	miscompares++; end end

module test_enclave_call_fault_gate;

	// ==========================================================
	// Design signals
	logic sys_clk, rst_b, wb_cyc, wb_stb, wb_we, wb_ack, req_valid, req_vmm;
	logic [31:0] wb_adr, wb_dat_w, wb_dat_r, res_leaf, rd;
	logic [3:0] wb_sel;
	logic [63:0] rax;
	logic [1:0] priv_level;
	logic pfx_lock, pfx_opsize, pfx_rep, pfx_vex, protect_en, v86_flag;
	logic sys_mgmt_mode, paging_en, native_fpu_err, task_switched;
	logic txn_active, inside_enclave, long_mode_active, code_seg_long;
	logic code_seg_default32, data_seg_expand_down, virt_op, guest_op;
	logic user_branch_track_state, sup_branch_track_state;
	logic res_valid, res_gp_zero, res_addr64;
	ecall_pkg::result_type res_kind;
	int miscompares = 0;
	int num_checks = 0;
	int num_disp = 0;

	enclave_call_fault_gate enclave_call_fault_gate_inst (
		.sys_clk(sys_clk), .rst_b(rst_b),
		.wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
		.wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
		.wb_ack(wb_ack),
		.req_valid(req_valid), .req_vmm(req_vmm), .rax(rax),
		.priv_level(priv_level), .pfx_lock(pfx_lock),
		.pfx_opsize(pfx_opsize), .pfx_rep(pfx_rep), .pfx_vex(pfx_vex),
		.protect_en(protect_en), .v86_flag(v86_flag),
		.sys_mgmt_mode(sys_mgmt_mode), .paging_en(paging_en),
		.native_fpu_err(native_fpu_err), .task_switched(task_switched),
		.txn_active(txn_active), .inside_enclave(inside_enclave),
		.long_mode_active(long_mode_active), .code_seg_long(code_seg_long),
		.code_seg_default32(code_seg_default32),
		.data_seg_expand_down(data_seg_expand_down),
		.virt_op(virt_op), .guest_op(guest_op),
		.user_branch_track_state(user_branch_track_state),
		.sup_branch_track_state(sup_branch_track_state),
		.res_valid(res_valid), .res_kind(res_kind),
		.res_gp_zero(res_gp_zero), .res_leaf(res_leaf),
		.res_addr64(res_addr64)
	);

	// ==========================================================
	// Clock and watchdog
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Whole run needs far under 2000 cycles
	initial begin
		#100000;
		miscompares++;
		end_sim();
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_sim

	// ==========================================================
	// Bus cycle: held until the edge that samples ack, data taken there;
	// only the watchdog ends a wait for an ack that never comes
	task automatic wb(input logic we, input logic [31:0] a, d);
		@(posedge sys_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat_w <= d;
		@(posedge sys_clk);
		while (wb_ack !== 1'b1) begin
			@(posedge sys_clk);
		end
		rd = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge sys_clk);
	endtask : wb

	// One request and its verdict one cycle later
	task automatic run(input logic v, input logic [63:0] a,
		input ecall_pkg::result_type e);
		@(posedge sys_clk);
		req_vmm <= v;
		rax <= a;
		req_valid <= 1'b1;
		@(posedge sys_clk);
		req_valid <= 1'b0;
		#1;
		`CHK(res_valid, 1'b1)
		`CHK(res_kind, e)
		`CHK(res_gp_zero, e == ecall_pkg::RES_GEN_PROT)
		if (e == ecall_pkg::RES_DISPATCH)
			num_disp++;
		@(posedge sys_clk);
	endtask : run

	// Clean state: protected, paged, 64-bit, at level pl; an edge passes
	// after it so that callers may override a field without a double drive
	task automatic base(input logic [1:0] pl);
		{pfx_lock, pfx_opsize, pfx_rep, pfx_vex} <= 4'h0;
		{protect_en, v86_flag, sys_mgmt_mode} <= 3'h4;
		{paging_en, native_fpu_err, task_switched, txn_active} <= 4'hC;
		{inside_enclave, long_mode_active, code_seg_long} <= 3'h3;
		{code_seg_default32, data_seg_expand_down} <= 2'h2;
		{virt_op, guest_op} <= {pl == 2'h0, 1'b0};
		{user_branch_track_state, sup_branch_track_state} <= 2'h0;
		priv_level <= pl;
		@(posedge sys_clk);
	endtask : base

	// ==========================================================
	// Scenarios
	task automatic t_regs();
		wb(1'b0, `ECG_OFF_CTRL, 32'h0);
		`CHK(rd, 32'h00000000)
		wb(1'b0, `ECG_OFF_MAP_HI, 32'h0);
		`CHK(rd, 32'h00000000)
		wb(1'b1, 32'h00000100, 32'hFFFFFFFF);
		wb(1'b0, 32'h00000100, 32'h0);
		`CHK(rd, 32'h00000000)
		wb(1'b1, `ECG_OFF_CTRL, 32'h0000001F);
		wb(1'b0, `ECG_OFF_CTRL, 32'h0);
		`CHK(rd, 32'h0000001F)
		$display("test regs done");
	endtask : t_regs

	task automatic t_user();
		int i;
		base(2'h3);
		run(1'b0, 64'hFFFFFFFF00000002, ecall_pkg::RES_DISPATCH);
		`CHK(res_leaf, 32'h00000002)
		`CHK(res_addr64, 1'b1)
		txn_active <= 1'b1;
		pfx_lock <= 1'b1;
		run(1'b0, 64'h2, ecall_pkg::RES_TXN_ABORT);
		for (i = 0; i < 4; i++) begin
			base(2'h3);
			{pfx_lock, pfx_opsize, pfx_rep, pfx_vex} <= 4'h1 << i;
			run(1'b0, 64'h2, ecall_pkg::RES_INVALID_OP);
		end
		for (i = 0; i < 3; i++) begin
			base(2'h3);
			{protect_en, v86_flag, sys_mgmt_mode} <= 3'h4 ^ (3'h4 >> i);
			run(1'b0, 64'h2, ecall_pkg::RES_INVALID_OP);
		end
		base(2'h2);
		task_switched <= 1'b1;
		run(1'b0, 64'h2, ecall_pkg::RES_NO_DEVICE);
		base(2'h2);
		run(1'b0, 64'h2, ecall_pkg::RES_INVALID_OP);
		base(2'h3);
		run(1'b0, 64'hA, ecall_pkg::RES_GEN_PROT);
		paging_en <= 1'b0;
		run(1'b0, 64'h2, ecall_pkg::RES_GEN_PROT);
		base(2'h3);
		native_fpu_err <= 1'b0;
		run(1'b0, 64'h2, ecall_pkg::RES_GEN_PROT);
		wb(1'b0, `ECG_OFF_STATUS, 32'h0);
		`CHK(rd, 32'h0000020B)
		base(2'h3);
		long_mode_active <= 1'b0;
		run(1'b0, 64'h3, ecall_pkg::RES_DISPATCH);
		`CHK(res_addr64, 1'b0)
		code_seg_default32 <= 1'b0;
		run(1'b0, 64'h3, ecall_pkg::RES_GEN_PROT);
		base(2'h3);
		inside_enclave <= 1'b1;
		run(1'b0, 64'h3, ecall_pkg::RES_GEN_PROT);
		run(1'b0, 64'h9, ecall_pkg::RES_DISPATCH);
		inside_enclave <= 1'b0;
		run(1'b0, 64'h9, ecall_pkg::RES_GEN_PROT);
		run(1'b0, 64'h0, ecall_pkg::RES_GEN_PROT);
		$display("test user done");
	endtask : t_user

	// Feature bits and branch tracking come from the control word
	task automatic t_ctrl();
		wb(1'b1, `ECG_OFF_CTRL, 32'h0000001E);
		run(1'b0, 64'h2, ecall_pkg::RES_GEN_PROT);
		base(2'h0);
		wb(1'b1, `ECG_OFF_CTRL, 32'h0000001D);
		run(1'b1, 64'h0, ecall_pkg::RES_GEN_PROT);
		base(2'h3);
		wb(1'b1, `ECG_OFF_CTRL, 32'h0000001B);
		run(1'b0, 64'h2, ecall_pkg::RES_INVALID_OP);
		wb(1'b1, `ECG_OFF_CTRL, 32'h0000005F);
		user_branch_track_state <= 1'b1;
		run(1'b0, 64'h2, ecall_pkg::RES_TRACK_VIOL);
		run(1'b0, 64'h3, ecall_pkg::RES_DISPATCH);
		{user_branch_track_state, sup_branch_track_state} <= 2'h1;
		run(1'b0, 64'h2, ecall_pkg::RES_DISPATCH);
		$display("test ctrl done");
	endtask : t_ctrl

	task automatic t_vmm();
		base(2'h0);
		wb(1'b1, `ECG_OFF_CTRL, 32'h00000017);
		run(1'b1, 64'h0, ecall_pkg::RES_INVALID_OP);
		wb(1'b1, `ECG_OFF_CTRL, 32'h0000000F);
		run(1'b1, 64'h1, ecall_pkg::RES_DISPATCH);
		guest_op <= 1'b1;
		run(1'b1, 64'h1, ecall_pkg::RES_INVALID_OP);
		wb(1'b1, `ECG_OFF_CTRL, 32'h0000003F);
		wb(1'b1, `ECG_OFF_MAP_LO, 32'h00000002);
		run(1'b1, 64'h1, ecall_pkg::RES_VM_EXIT);
		run(1'b1, 64'h0, ecall_pkg::RES_DISPATCH);
		run(1'b1, 64'h40, ecall_pkg::RES_GEN_PROT);
		wb(1'b1, `ECG_OFF_MAP_HI, 32'h80000000);
		run(1'b1, 64'h40, ecall_pkg::RES_VM_EXIT);
		base(2'h1);
		virt_op <= 1'b1;
		run(1'b1, 64'h0, ecall_pkg::RES_INVALID_OP);
		base(2'h0);
		virt_op <= 1'b0;
		run(1'b1, 64'h0, ecall_pkg::RES_INVALID_OP);
		base(2'h0);
		code_seg_long <= 1'b0;
		run(1'b1, 64'h0, ecall_pkg::RES_INVALID_OP);
		base(2'h0);
		sys_mgmt_mode <= 1'b1;
		run(1'b1, 64'h0, ecall_pkg::RES_INVALID_OP);
		base(2'h0);
		data_seg_expand_down <= 1'b1;
		run(1'b1, 64'h0, ecall_pkg::RES_DISPATCH);
		long_mode_active <= 1'b0;
		run(1'b1, 64'h0, ecall_pkg::RES_GEN_PROT);
		base(2'h0);
		paging_en <= 1'b0;
		run(1'b1, 64'h2, ecall_pkg::RES_GEN_PROT);
		wb(1'b0, `ECG_OFF_COUNT, 32'h0);
		`CHK(rd, num_disp)
		$display("test vmm done");
	endtask : t_vmm

	// ==========================================================
	// Main sequence: bus and request inputs at zero except wb_sel with all lanes set, core in clean user state, reset held 20 cycles
	initial begin
		{rst_b, wb_cyc, wb_stb, wb_we, req_valid, req_vmm} = 6'h00;
		{wb_adr, wb_dat_w, rax} = 128'h0;
		wb_sel = 4'hF;
		base(2'h3);
		repeat (19) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge sys_clk);
		t_regs();
		t_user();
		t_ctrl();
		t_vmm();
		end_sim();
	end

endmodule : test_enclave_call_fault_gate
